//--- logic/dtm_pkg.sv
// Purpose: shared constants and types for the dual timer mode/control block
// Assumes: 8-bit special-function register space, single core clock
// Notes:   offsets are byte addresses in the special-function space
`default_nettype none

package dtm_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [7:0] DTM_ADDR_CONTROL = 8'h88; // timer_pair_control
  localparam logic [7:0] DTM_ADDR_MODE    = 8'h89; // timer_pair_mode
  localparam logic [7:0] DTM_ADDR_T0_LOW  = 8'h8a;
  localparam logic [7:0] DTM_ADDR_T1_LOW  = 8'h8b;
  localparam logic [7:0] DTM_ADDR_T0_HIGH = 8'h8c;
  localparam logic [7:0] DTM_ADDR_T1_HIGH = 8'h8d;

  // bit addresses of the control register sit at 0x88..0x8f
  localparam logic [4:0] DTM_BIT_PAGE     = 5'h11;

  //////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int DTM_T1_OVF  = 7;
  localparam int DTM_T1_RUN  = 6;
  localparam int DTM_T0_OVF  = 5;
  localparam int DTM_T0_RUN  = 4;
  localparam int DTM_X1_FLAG = 3;
  localparam int DTM_X1_EDGE = 2;
  localparam int DTM_X0_FLAG = 1;
  localparam int DTM_X0_EDGE = 0;

  // mode register fields
  localparam int DTM_T1_GATE = 7;
  localparam int DTM_T1_SRC  = 6;
  localparam int DTM_T1_MLSB = 4;
  localparam int DTM_T0_GATE = 3;
  localparam int DTM_T0_SRC  = 2;
  localparam int DTM_T0_MLSB = 0;

  //////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] DTM_CONTROL_RST = 8'h00;
  localparam logic [7:0] DTM_MODE_RST    = 8'h00;
  localparam logic [7:0] DTM_COUNT_RST   = 8'h00;

  // counting limits
  localparam logic [4:0] DTM_PRESCALE_MAX = 5'h1f;
  localparam logic [7:0] DTM_BYTE_MAX     = 8'hff;

  typedef enum logic [1:0] {
    DTM_MODE_PRESCALE13 = 2'b00,
    DTM_MODE_CASCADE16  = 2'b01,
    DTM_MODE_RELOAD8    = 2'b10,
    DTM_MODE_SPLIT      = 2'b11
  } dtm_mode_t;

endpackage : dtm_pkg

`default_nettype wire

//--- logic/dtm_cnt_if.sv
// Purpose: carrier between the control logic and one counting unit
// Assumes: all signals in the sys_clk domain
// Notes:   tick and hi_tick are one-cycle enables, ovf pulses registered
`default_nettype none

interface dtm_cnt_if;
  import dtm_pkg::*;

  dtm_mode_t   mode;     // selected operating mode
  logic        tick;     // advance the main count this cycle
  logic        hi_tick;  // advance the high byte alone in split mode
  logic        wr_lo;    // software write of the low byte
  logic        wr_hi;    // software write of the high byte
  logic [7:0]  wdata;    // software write data
  logic [7:0]  tl;       // low byte value
  logic [7:0]  th;       // high byte value
  logic        ovf;      // main count rolled over
  logic        ovf_hi;   // split high byte rolled over

  modport ctrl (output mode, tick, hi_tick, wr_lo, wr_hi, wdata,
                input  tl, th, ovf, ovf_hi);
  modport unit (input  mode, tick, hi_tick, wr_lo, wr_hi, wdata,
                output tl, th, ovf, ovf_hi);

endinterface : dtm_cnt_if

`default_nettype wire

//--- logic/dtm_count_unit.sv
// Purpose: one timer/counter data path, low and high byte
// Assumes: tick already qualified by run, gating and source select
// Notes:   SPLIT_CAPABLE enables the two independent 8-bit halves
`default_nettype none

module dtm_count_unit
  import dtm_pkg::*;
#(
  parameter bit SPLIT_CAPABLE = 1'b0      // supports split mode
) (
  input  wire logic sys_clk,              // core clock
  input  wire logic arst_n,               // async reset, active low
  input  wire logic clk_en,               // freezes all state when low
  dtm_cnt_if.unit   c                     // control side
);

  logic [7:0] low;
  logic [7:0] high;
  logic       ovf_q;
  logic       ovf_hi_q;

  assign c.tl     = low;
  assign c.th     = high;
  assign c.ovf    = ovf_q;
  assign c.ovf_hi = ovf_hi_q;

  ////////////////////////////////////////////////////////////////////////////
  // counting; a software byte write wins over a count in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      low      <= DTM_COUNT_RST;
      high     <= DTM_COUNT_RST;
      ovf_q    <= 1'b0;
      ovf_hi_q <= 1'b0;
    end else if (clk_en) begin
      ovf_q    <= 1'b0;
      ovf_hi_q <= 1'b0;
      if (c.tick) begin
        case (c.mode)
          DTM_MODE_PRESCALE13: begin
            // upper three low-byte bits simply hold their value
            low[4:0] <= low[4:0] + 5'h01;
            if (low[4:0] == DTM_PRESCALE_MAX) begin
              high <= high + 8'h01;
              ovf_q <= (high == DTM_BYTE_MAX);
            end
          end
          DTM_MODE_CASCADE16: begin
            {high, low} <= {high, low} + 16'h0001;
            ovf_q <= (high == DTM_BYTE_MAX) && (low == DTM_BYTE_MAX);
          end
          DTM_MODE_RELOAD8: begin
            if (low == DTM_BYTE_MAX) begin
              low   <= high;
              ovf_q <= 1'b1;
            end else begin
              low <= low + 8'h01;
            end
          end
          DTM_MODE_SPLIT: begin
            if (SPLIT_CAPABLE) begin
              low   <= low + 8'h01;
              ovf_q <= (low == DTM_BYTE_MAX);
            end
          end
          default: begin
            low <= low;
          end
        endcase
      end
      // high half of the split pair runs on its own enable
      if (SPLIT_CAPABLE && c.mode == DTM_MODE_SPLIT && c.hi_tick) begin
        high     <= high + 8'h01;
        ovf_hi_q <= (high == DTM_BYTE_MAX);
      end
      if (c.wr_lo) begin
        low <= c.wdata;
      end
      if (c.wr_hi) begin
        high <= c.wdata;
      end
    end
  end

endmodule : dtm_count_unit

`default_nettype wire

//--- logic/dtm_timer_pair.sv
// Purpose: mode and control logic for timer/counters 0 and 1 and the two
//          external interrupt request flags
// Assumes: pins synchronous to sys_clk; core gives one-cycle vector pulses
// Notes:   byte access via sfr_* ports, single-bit access via bit_* ports
//
// Functional notes
// - timer 1 mode 01 is a plain 16-bit cascaded counter, no prescaler.
// - timer 1 mode 10 counts low byte, reloads it from high on overflow.
// - timer 1 mode 11 holds its count stopped.
// - timer 0 gating set: count only while pin 0 high and run set.
// - timer 0 gating clear: count whenever run is set.
// - timer 0 source select picks count pin events or the system clock.
// - timer 0 mode 00: high byte counter fed by 5-bit low prescaler.
// - timer 0 mode 01 is a 16-bit cascaded counter, no prescaler.
// - timer 0 mode 10 counts low byte, reloads from high on overflow.
// - timer 0 mode 11 splits low (own controls) and high (timer 1 run).
// - timer 1 overflow sets its flag, except in timer 0 mode 11 where timer 0's high half sets it; vectoring clears it.
// - timer 0 overflow sets its flag; vectoring clears it.
// - timer 1 run bit turns timer 1 on and off.
// - timer 0 run bit turns timer 0 on and off.
// - interrupt 1 flag set by falling edge or low level, per its type.
// - edge flags clear on vectoring; level flags follow the source.
// - interrupt 1 type bit set selects edge, clear selects low level.
// - interrupt 0 flag set by falling edge or low level, per its type.
// - interrupt 0 type bit set selects edge, clear selects low level.
// - control register bits reachable singly at bit addresses 0x88-0x8f.
// - timer 1 gating set: count only while pin 1 high and run set.
// - timer 1 mode 00: high byte counter fed by 5-bit low prescaler.
// - count pin increments on a high sample followed by a low sample.
`default_nettype none

module dtm_timer_pair
  import dtm_pkg::*;
(
  input  wire logic       sys_clk,            // core clock, 40 MHz
  input  wire logic       arst_n,             // async reset, active low
  input  wire logic       clk_en,             // freezes all state when low
  input  wire logic [7:0] sfr_addr,           // byte register address
  input  wire logic       sfr_wr,             // byte write strobe
  input  wire logic       sfr_rd,             // byte read strobe
  input  wire logic [7:0] sfr_wdata,          // byte write data
  output logic      [7:0] sfr_rdata,          // byte read data, registered
  input  wire logic [7:0] bit_addr,           // bit address
  input  wire logic       bit_wr,             // bit write strobe
  input  wire logic       bit_rd,             // bit read strobe
  input  wire logic       bit_wdata,          // bit write value
  output logic            bit_rdata,          // bit read value, registered
  input  wire logic       vector_timer0,      // core vectors to timer 0 isr
  input  wire logic       vector_timer1,      // core vectors to timer 1 isr
  input  wire logic       vector_ext_irq0,    // core vectors to ext irq 0
  input  wire logic       vector_ext_irq1,    // core vectors to ext irq 1
  input  wire logic       ext_irq0_pin,       // external interrupt pin 0
  input  wire logic       ext_irq1_pin,       // external interrupt pin 1
  input  wire logic       timer0_count_input, // timer 0 count pin
  input  wire logic       timer1_count_input, // timer 1 count pin
  output logic            timer0_overflow_flag, // request, from flop
  output logic            timer1_overflow_flag, // request, from flop
  output logic            ext_irq0_flag,      // request, from flop
  output logic            ext_irq1_flag       // request, from flop
);

  logic [7:0] timer_pair_control;
  logic [7:0] timer_pair_mode;
  logic [7:0] next_control;
  logic [1:0] cnt_smp;       // count pins, current sample
  logic [1:0] cnt_old;       // count pins, previous sample
  logic [1:0] irq_old;       // interrupt pins, previous sample
  logic [1:0] cnt_event;
  logic [1:0] tick;
  logic [1:0] wr_lo;
  logic [1:0] wr_hi;
  logic [1:0] ovf;
  logic [1:0] ovf_hi;
  logic [7:0] tl [2];
  logic [7:0] th [2];
  logic [1:0] run;
  logic [1:0] gate;
  logic [1:0] src;
  logic [1:0] irq_pin;
  dtm_mode_t  mode [2];
  logic       t0_split;
  logic       bit_hit;
  logic       set_tf0;
  logic       set_tf1;
  logic [1:0] irq_fall;

  assign timer0_overflow_flag = timer_pair_control[DTM_T0_OVF];
  assign timer1_overflow_flag = timer_pair_control[DTM_T1_OVF];
  assign ext_irq0_flag        = timer_pair_control[DTM_X0_FLAG];
  assign ext_irq1_flag        = timer_pair_control[DTM_X1_FLAG];

  ////////////////////////////////////////////////////////////////////////////
  // field views of the two control registers
  assign run      = {timer_pair_control[DTM_T1_RUN],
                     timer_pair_control[DTM_T0_RUN]};
  assign gate     = {timer_pair_mode[DTM_T1_GATE],
                     timer_pair_mode[DTM_T0_GATE]};
  assign src      = {timer_pair_mode[DTM_T1_SRC], timer_pair_mode[DTM_T0_SRC]};
  assign mode[0]  = dtm_mode_t'(timer_pair_mode[DTM_T0_MLSB +: 2]);
  assign mode[1]  = dtm_mode_t'(timer_pair_mode[DTM_T1_MLSB +: 2]);
  assign irq_pin  = {ext_irq1_pin, ext_irq0_pin};
  assign t0_split = (mode[0] == DTM_MODE_SPLIT);
  assign bit_hit  = (bit_addr[7:3] == DTM_BIT_PAGE);

  ////////////////////////////////////////////////////////////////////////////
  // pin samples; a count needs a high sample then a low one, so the pin
  // must hold each level for a full cycle or an edge can be missed
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_smp <= 2'h0;
      cnt_old <= 2'h0;
      irq_old <= 2'h0;
    end else if (clk_en) begin
      cnt_smp <= {timer1_count_input, timer0_count_input};
      cnt_old <= cnt_smp;
      irq_old <= irq_pin;
    end
  end

  assign cnt_event = cnt_old & ~cnt_smp;
  assign irq_fall  = irq_old & ~irq_pin;

  ////////////////////////////////////////////////////////////////////////////
  // per-timer count enable and data path
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_timer
      dtm_cnt_if cif ();

      // gating pin only matters when gating is set
      assign tick[gi] = run[gi] && (!gate[gi] || irq_pin[gi])
                        && (src[gi] ? cnt_event[gi] : 1'b1)
                        && !(gi == 1 && mode[gi] == DTM_MODE_SPLIT);

      assign wr_lo[gi] = sfr_wr && (sfr_addr == (gi == 0 ? DTM_ADDR_T0_LOW
                                                         : DTM_ADDR_T1_LOW));
      assign wr_hi[gi] = sfr_wr && (sfr_addr == (gi == 0 ? DTM_ADDR_T0_HIGH
                                                         : DTM_ADDR_T1_HIGH));

      assign cif.mode    = mode[gi];
      assign cif.tick    = tick[gi];
      // split high half is a timer only, switched by timer 1's run bit
      assign cif.hi_tick = (gi == 0) ? run[1] : 1'b0;
      assign cif.wr_lo   = wr_lo[gi];
      assign cif.wr_hi   = wr_hi[gi];
      assign cif.wdata   = sfr_wdata;
      assign tl[gi]      = cif.tl;
      assign th[gi]      = cif.th;
      assign ovf[gi]     = cif.ovf;
      assign ovf_hi[gi]  = cif.ovf_hi;

      dtm_count_unit #(
        .SPLIT_CAPABLE (gi == 0)
      ) u_count (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .c       (cif.unit)
      );
    end
  endgenerate

  // in split mode timer 1's flag belongs to timer 0's high half
  assign set_tf0 = ovf[0];
  assign set_tf1 = t0_split ? ovf_hi[0] : ovf[1];

  ////////////////////////////////////////////////////////////////////////////
  // control register next value: software, then vector clears, then
  // hardware sets, so an event in the clearing cycle is never lost
  always_comb begin
    next_control = timer_pair_control;
    if (sfr_wr && sfr_addr == DTM_ADDR_CONTROL) begin
      next_control = sfr_wdata;
    end
    if (bit_wr && bit_hit) begin
      next_control[bit_addr[2:0]] = bit_wdata;
    end
    if (vector_timer0) begin
      next_control[DTM_T0_OVF] = 1'b0;
    end
    if (vector_timer1) begin
      next_control[DTM_T1_OVF] = 1'b0;
    end
    if (set_tf0) begin
      next_control[DTM_T0_OVF] = 1'b1;
    end
    if (set_tf1) begin
      next_control[DTM_T1_OVF] = 1'b1;
    end
    // edge type: latched on a fall, cleared on vectoring
    if (next_control[DTM_X0_EDGE]) begin
      if (vector_ext_irq0) begin
        next_control[DTM_X0_FLAG] = 1'b0;
      end
      if (irq_fall[0]) begin
        next_control[DTM_X0_FLAG] = 1'b1;
      end
    end else begin
      // level type: the source owns the flag by holding the pin low
      next_control[DTM_X0_FLAG] = !irq_pin[0];
    end
    if (next_control[DTM_X1_EDGE]) begin
      if (vector_ext_irq1) begin
        next_control[DTM_X1_FLAG] = 1'b0;
      end
      if (irq_fall[1]) begin
        next_control[DTM_X1_FLAG] = 1'b1;
      end
    end else begin
      next_control[DTM_X1_FLAG] = !irq_pin[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register storage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_pair_control <= DTM_CONTROL_RST;
    end else if (clk_en) begin
      timer_pair_control <= next_control;
    end
  end

  // mode register, byte access only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_pair_mode <= DTM_MODE_RST;
    end else if (clk_en && sfr_wr && sfr_addr == DTM_ADDR_MODE) begin
      timer_pair_mode <= sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered read data; unmapped addresses read as zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (clk_en && sfr_rd) begin
      case (sfr_addr)
        DTM_ADDR_CONTROL: sfr_rdata <= timer_pair_control;
        DTM_ADDR_MODE:    sfr_rdata <= timer_pair_mode;
        DTM_ADDR_T0_LOW:  sfr_rdata <= tl[0];
        DTM_ADDR_T1_LOW:  sfr_rdata <= tl[1];
        DTM_ADDR_T0_HIGH: sfr_rdata <= th[0];
        DTM_ADDR_T1_HIGH: sfr_rdata <= th[1];
        default:          sfr_rdata <= 8'h00;
      endcase
    end
  end

  // single-bit read of the control register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_rdata <= 1'b0;
    end else if (clk_en && bit_rd) begin
      bit_rdata <= bit_hit && timer_pair_control[bit_addr[2:0]];
    end
  end

endmodule : dtm_timer_pair

`default_nettype wire

//--- tb/dtm_far_model.sv
// Purpose: far side model, interrupt pins, count pins, core vectoring
// Assumes: driven 1 ns after the rising edge
// Notes:   count levels held two cycles, above the one cycle minimum
`default_nettype none

module dtm_far_model (
  input  wire logic sys_clk,            // core clock
  output logic      ext_irq0_pin,       // interrupt pin 0
  output logic      ext_irq1_pin,       // interrupt pin 1
  output logic      timer0_count_input, // count pin 0
  output logic      timer1_count_input, // count pin 1
  output logic      vector_timer0,      // vector, timer 0
  output logic      vector_timer1,      // vector, timer 1
  output logic      vector_ext_irq0,    // vector, ext irq 0
  output logic      vector_ext_irq1     // vector, ext irq 1
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] irq_q = 2'h3;
  logic [1:0] cnt_q = 2'h0;
  logic [3:0] vec_q = 4'h0;

  //////////////////////////////////////////////////
  // pins idle high for interrupts, low for counts
  assign {ext_irq1_pin, ext_irq0_pin} = irq_q;
  assign {timer1_count_input, timer0_count_input} = cnt_q;
  assign {vector_ext_irq1, vector_ext_irq0} = vec_q[3:2];
  assign {vector_timer1, vector_timer0} = vec_q[1:0];

  // level source owns a level-type flag by holding its pin
  task automatic set_irq(input int i, input logic v);
    irq_q[i] = v;
  endtask : set_irq

  // full high then low periods, so every level is sampled
  task automatic pulses(input int i, input int k);
    for (int n = 0; n < k; n++) begin
      for (int l = 1; l >= 0; l--) begin
        cnt_q[i] = l[0];
        repeat (2) @(posedge sys_clk);
        #1;
      end
    end
  endtask : pulses

  // one cycle vector pulse: 0,1 timers, 2,3 ext irqs
  task automatic vec(input int w);
    vec_q[w] = 1'b1;
    @(posedge sys_clk);
    #1;
    vec_q[w] = 1'b0;
  endtask : vec
endmodule : dtm_far_model
`default_nettype wire

//--- tb/dtm_timer_pair_assertions.sv
// Purpose: port checker for dtm_timer_pair
// Assumes: one clock domain, async active-low reset
// Notes:   edge-type bits are shadowed from the bus writes
`default_nettype none

module dtm_timer_pair_chk
  import dtm_pkg::*;
(
  input wire logic       sys_clk,              // clock
  input wire logic       arst_n,               // reset
  input wire logic       clk_en,               // enable
  input wire logic [7:0] sfr_addr,             // byte addr
  input wire logic       sfr_wr,               // byte wr
  input wire logic [7:0] sfr_wdata,            // byte data
  input wire logic [7:0] bit_addr,             // bit addr
  input wire logic       bit_wr,               // bit wr
  input wire logic       bit_wdata,            // bit data
  input wire logic       vector_timer0,        // vector t0
  input wire logic       vector_timer1,        // vector t1
  input wire logic       vector_ext_irq0,      // vector x0
  input wire logic       ext_irq0_pin,         // pin 0
  input wire logic       ext_irq1_pin,         // pin 1
  input wire logic       timer0_overflow_flag, // t0 flag
  input wire logic       timer1_overflow_flag, // t1 flag
  input wire logic       ext_irq0_flag,        // x0 flag
  input wire logic       ext_irq1_flag         // x1 flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic x0e;
  logic x1e;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  //////////////////////////////////////////////////
  // shadow of the trigger-type bits; a bit write wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      x0e <= 1'b0;
      x1e <= 1'b0;
    end else if (clk_en) begin
      if (sfr_wr && sfr_addr == DTM_ADDR_CONTROL) begin
        x0e <= sfr_wdata[DTM_X0_EDGE];
        x1e <= sfr_wdata[DTM_X1_EDGE];
      end
      if (bit_wr && bit_addr == 8'h88) x0e <= bit_wdata;
      if (bit_wr && bit_addr == 8'h8a) x1e <= bit_wdata;
    end
  end

  //////////////////////////////////////////////////
  AST_RST_QUIET: assert property (
    $rose(arst_n) |-> !(timer0_overflow_flag || timer1_overflow_flag
      || ext_irq0_flag || ext_irq1_flag))
    else $error("flag set straight after reset");
  AST_T0_CLR: assert property (
    $fell(timer0_overflow_flag) |-> $past(vector_timer0 || sfr_wr || bit_wr))
    else $error("timer 0 flag dropped without cause");
  AST_T1_CLR: assert property (
    $fell(timer1_overflow_flag) |-> $past(vector_timer1 || sfr_wr || bit_wr))
    else $error("timer 1 flag dropped without cause");
  AST_X0_LVL: assert property (
    !x0e && clk_en |=> ext_irq0_flag == !$past(ext_irq0_pin))
    else $error("level flag 0 does not follow pin");
  AST_X1_LVL: assert property (
    !x1e && clk_en |=> ext_irq1_flag == !$past(ext_irq1_pin))
    else $error("level flag 1 does not follow pin");
  AST_X0_EDGE: assert property (
    x0e && clk_en && $past(clk_en) && $fell(ext_irq0_pin) |=> ext_irq0_flag)
    else $error("falling edge on pin 0 missed");
  AST_X1_EDGE: assert property (
    x1e && clk_en && $past(clk_en) && $fell(ext_irq1_pin) |=> ext_irq1_flag)
    else $error("falling edge on pin 1 missed");
  AST_X0_VEC: assert property (
    x0e && clk_en && vector_ext_irq0 && ext_irq0_pin && !sfr_wr && !bit_wr
      |=> !ext_irq0_flag)
    else $error("edge flag 0 kept after vectoring");
endmodule : dtm_timer_pair_chk

bind dtm_timer_pair dtm_timer_pair_chk u_chk (.sys_clk, .arst_n, .clk_en,
  .sfr_addr, .sfr_wr, .sfr_wdata, .bit_addr, .bit_wr, .bit_wdata,
  .vector_timer0, .vector_timer1, .vector_ext_irq0, .ext_irq0_pin,
  .ext_irq1_pin, .timer0_overflow_flag, .timer1_overflow_flag,
  .ext_irq0_flag, .ext_irq1_flag);
`default_nettype wire

//--- tb/test_dual_timer_mode_control.sv
// Purpose: self-checking bench for dtm_timer_pair
// Assumes: dtm_far_model drives pins and vector pulses
// Notes:   mode-test counts come from ref_count, the others from m and k, never from the design
`default_nettype none

module test_dual_timer_mode_control
  import dtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, arst_n, clk_en, sfr_wr, sfr_rd;
  logic        bit_wr, bit_rd, bit_wdata, bit_rdata;
  logic [7:0]  sfr_addr, sfr_wdata, bit_addr, sfr_rdata, q, th, tl, lo_a, hi_a;
  logic        vector_timer0, vector_timer1, vector_ext_irq0, vector_ext_irq1;
  logic        ext_irq0_pin, ext_irq1_pin;
  logic        timer0_count_input, timer1_count_input;
  logic        timer0_overflow_flag, timer1_overflow_flag;
  logic        ext_irq0_flag, ext_irq1_flag;
  logic [16:0] exp_v;
  int          err_total, checks_done, m, k;
  wire  [1:0]  xf = {ext_irq1_flag, ext_irq0_flag};
  wire  [1:0]  tf = {timer1_overflow_flag, timer0_overflow_flag};

  dtm_timer_pair dut (.sys_clk, .arst_n, .clk_en, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .sfr_rdata, .bit_addr, .bit_wr, .bit_rd,
    .bit_wdata, .bit_rdata, .vector_timer0, .vector_timer1,
    .vector_ext_irq0, .vector_ext_irq1, .ext_irq0_pin, .ext_irq1_pin,
    .timer0_count_input, .timer1_count_input, .timer0_overflow_flag,
    .timer1_overflow_flag, .ext_irq0_flag, .ext_irq1_flag);
  dtm_far_model far (.sys_clk, .ext_irq0_pin, .ext_irq1_pin,
    .timer0_count_input, .timer1_count_input, .vector_timer0,
    .vector_timer1, .vector_ext_irq0, .vector_ext_irq1);

  //////////////////////////////////////////////////
  // expected {overflow, high, low} after n counts
  function automatic logic [16:0] ref_count(input logic [1:0] md,
      input logic [7:0] hi, input logic [7:0] lo, input int n);
    logic ov;
    ov = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (md == 2'b00) begin
        if (lo[4:0] == 5'h1f && hi == 8'hff) ov = 1'b1;
        if (lo[4:0] == 5'h1f) hi = hi + 8'h01;
        lo[4:0] = lo[4:0] + 5'h01;
      end else if (md == 2'b01) begin
        if ({hi, lo} == 16'hffff) ov = 1'b1;
        {hi, lo} = {hi, lo} + 16'h0001;
      end else begin
        if (lo == 8'hff) ov = 1'b1;
        lo = (lo == 8'hff) ? hi : lo + 8'h01;
      end
    end
    return {ov, hi, lo};
  endfunction : ref_count

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // strobe low for one edge between accesses, never re-raised same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    d = sfr_rdata;
    sfr_rd = 1'b0;
    cyc(1);
  endtask : rd

  task automatic bwr(input logic [7:0] a, input logic v);
    bit_addr = a;
    bit_wdata = v;
    bit_wr = 1'b1;
    cyc(1);
    bit_wr = 1'b0;
    cyc(1);
  endtask : bwr

  task automatic brd(input logic [7:0] a, output logic v);
    bit_addr = a;
    bit_rd = 1'b1;
    cyc(1);
    v = bit_rdata;
    bit_rd = 1'b0;
    cyc(1);
  endtask : brd

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  //////////////////////////////////////////////////
  // 40 MHz clock and a watchdog well past the test length
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end

  // main sequence
  initial begin
    {arst_n, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata} = 6'h00;
    {sfr_addr, sfr_wdata, bit_addr} = 24'h000000;
    clk_en = 1'b1;
    err_total = 0;
    checks_done = 0;
    void'($urandom(32'hcc00));
    cyc(5);
    arst_n = 1'b1;
    for (int a = 8'h88; a <= 8'h8e; a++) begin
      rd(8'(a), q);
      chk(q, 8'h00);
    end
    $display("test reset done");
    for (int t = 0; t < 2; t++) begin
      lo_a = t ? 8'h8b : 8'h8a;
      hi_a = t ? 8'h8d : 8'h8c;
      for (int md = 0; md < 3; md++) begin
        th = $urandom_range(1) ? 8'hff : 8'($urandom);
        tl = 8'hf0 | 8'($urandom_range(15));
        m = $urandom_range(40);
        wr(8'h89, t ? {2'b00, 2'(md), 4'h0} : {6'h00, 2'(md)});
        wr(lo_a, tl);
        wr(hi_a, th);
        wr(8'h88, 8'h00);
        bwr(8'h8c + 8'(2 * t), 1'b1);
        cyc(m);
        bwr(8'h8c + 8'(2 * t), 1'b0);
        exp_v = ref_count(2'(md), th, tl, m + 2);
        rd(lo_a, q);
        chk(q, exp_v[7:0]);
        rd(hi_a, q);
        chk(q, exp_v[15:8]);
        brd(8'h8d + 8'(2 * t), q[0]);
        chk({7'h00, q[0]}, {7'h00, exp_v[16]});
        far.vec(t);
        chk({7'h00, tf[t]}, 8'h00);
      end
    end
    $display("test modes done");
    m = $urandom_range(40);
    wr(8'h89, 8'h33);
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'h00);
    wr(8'h8b, 8'h5a);
    wr(8'h88, 8'h50);
    cyc(m);
    clk_en = 1'b0;
    cyc(3); // frozen edges must not count
    clk_en = 1'b1;
    wr(8'h88, 8'h00);
    rd(8'h8a, q);
    chk(q, 8'(m + 2));
    rd(8'h8c, q);
    chk(q, 8'(m + 2));
    rd(8'h8b, q);
    chk(q, 8'h5a);
    $display("test split done");
    for (int t = 0; t < 2; t++) begin
      lo_a = t ? 8'h8b : 8'h8a;
      m = $urandom_range(30);
      k = $urandom_range(8, 1);
      far.set_irq(t, 1'b0);
      wr(8'h89, t ? 8'h90 : 8'h09);
      wr(lo_a, 8'h00);
      wr(t ? 8'h8d : 8'h8c, 8'h00);
      wr(8'h88, t ? 8'h40 : 8'h10);
      cyc(5);
      far.set_irq(t, 1'b1);
      cyc(m);
      wr(8'h88, 8'h00);
      rd(lo_a, q);
      chk(q, 8'(m + 1));
      wr(8'h89, t ? 8'h50 : 8'h05);
      wr(lo_a, 8'h00);
      far.set_irq(t, 1'b0);
      wr(8'h88, t ? 8'h40 : 8'h10);
      far.pulses(t, k);
      cyc(4);
      wr(8'h88, 8'h00);
      rd(lo_a, q);
      chk(q, 8'(k));
      far.set_irq(t, 1'b1);
      cyc(2);
      wr(8'h88, t ? 8'h04 : 8'h01);
      chk({7'h00, xf[t]}, 8'h00);
      far.set_irq(t, 1'b0);
      cyc(2);
      chk({7'h00, xf[t]}, 8'h01);
      far.set_irq(t, 1'b1);
      cyc(1);
      far.vec(2 + t);
      chk({7'h00, xf[t]}, 8'h00);
      wr(8'h88, 8'h00);
      far.set_irq(t, 1'b0);
      cyc(2);
      far.vec(2 + t);
      chk({7'h00, xf[t]}, 8'h01);
      far.set_irq(t, 1'b1);
      cyc(2);
      chk({7'h00, xf[t]}, 8'h00);
    end
    $display("test gate count irq done");
    finish_test();
  end
endmodule : test_dual_timer_mode_control
`default_nettype wire
